// File: design/motion_regs.vh
`ifndef MOTION_REGS_VH
`define MOTION_REGS_VH
// register indices; byte address is four times the index
`define IDX_FOC 7'h06
`define IDX_STAT1 7'h16
`define IDX_STAT2 7'h17
`define IDX_ODET 7'h1A
`define IDX_WM_LO 7'h36
`define IDX_WM_HI 7'h37
`define IDX_EN1 7'h40
`define IDX_EN2 7'h41
`define IDX_PINCFG 7'h42
`define IDX_ROUTE 7'h43
`define IDX_UPDN 7'h44
`define IDX_OCFG 7'h45
`define IDX_LIM_LO 7'h46
`define IDX_LIM_HI 7'h47
`define IDX_SLP_LO 7'h48
`define IDX_SLP_HI 7'h49
`define IDX_HYS_LO 7'h4A
`define IDX_HYS_HI 7'h4B
`define IDX_SMD_LO 7'h5A
`define IDX_SMD_HI 7'h5B
`define IDX_SMD_TIME 7'h5C
`define IDX_HG_LO 7'h5E
`define IDX_HG_HI 7'h5F
`define IDX_HG_DUR 7'h60
`define IDX_LG_LO 7'h61
`define IDX_LG_HI 7'h62
`define IDX_LG_DUR 7'h63
`define IDX_FF_THR 7'h64
`define IDX_FF_DUR 7'h65
`define IDX_HG_AXES 7'h66
`define REG_COUNT 128
`define RST_BYTE 8'h00
// bit positions
`define B_ORIENT 0
`define B_HIGHG 6
`define B_LOWG 7
`define B_FF 0
`define B_ADRDY 1
`define B_GDRDY 2
`define B_WM 3
`define B_SMD 4
`define B_DOWN 2
`define B_UPDN 7
`define B_ACT_LOW 7
`define B_OD1 1
`define B_OD2 3
`define B_LATCH 0
`define B_TO_PIN2 1
// mode and blocking codes
`define OMODE_HIGH 2'b01
`define OMODE_LOW 2'b10
`define BLK_OFF 2'b00
`define BLK_BASIC 2'b01
`define BLK_SLOPE 2'b10
`define BLK_FULL 2'b11
// offset compensation command range
`define FOC_FIRST 8'h90
`define FOC_LAST 8'h95
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
// timing
`define CLK_NS 20
`define MS_NS 1000000
`define BLOCK_MS 7'h64
`define FF_MS_PER_LSB 2
`endif

// File: design/motion_event_engine.v
`timescale 1ns/1ns
`include "motion_regs.vh"
module motion_event_engine #(
  parameter MS_CYCLES = `MS_NS / `CLK_NS,
  parameter WM_BITS = 11
) (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // axi4-lite write
  input wire [11:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [11:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // samples and fifo level
  input wire [15:0] acc_x,
  input wire [15:0] acc_y,
  input wire [15:0] acc_z,
  input wire acc_valid,
  input wire gyro_valid,
  input wire [WM_BITS-1:0] fifo_count,
  // interrupt pins
  output wire first_interrupt_pin_out,
  output wire first_interrupt_pin_oe,
  output wire second_interrupt_pin_out,
  output wire second_interrupt_pin_oe,
  // offset compensation request
  output reg foc_start,
  output reg [1:0] foc_axis,
  output reg foc_negative
);
  localparam [19:0] MS_LAST = MS_CYCLES[19:0] - 20'h0_0001;
  localparam [6:0] BLOCK_MS_L = `BLOCK_MS;
  localparam [2:0] SMD_IDLE = 3'b001;
  localparam [2:0] SMD_BLOCK = 3'b010;
  localparam [2:0] SMD_PROOF = 3'b100;

  // absolute value of a sign-extended quantity
  function [17:0] abs18;
    input [17:0] v;
    begin
      abs18 = v[17] ? (~v + 18'h0_0001) : v;
    end
  endfunction

  // any of three slopes above a threshold
  function over_any;
    input [17:0] a;
    input [17:0] b;
    input [17:0] c;
    input [17:0] t;
    begin
      over_any = (a > t) || (b > t) || (c > t);
    end
  endfunction

  reg [7:0] cfg [0:`REG_COUNT-1];
  reg [7:0] stat1_reg, stat2_reg;
  reg [1:0] ocode_reg;
  reg down_reg;
  reg [15:0] px_reg, py_reg, pz_reg;
  integer i;

  // configuration fields
  wire [15:0] hyst = {cfg[`IDX_HYS_HI], cfg[`IDX_HYS_LO]};
  wire [15:0] big_lim = {cfg[`IDX_LIM_HI], cfg[`IDX_LIM_LO]};
  wire [15:0] slp_thr = {cfg[`IDX_SLP_HI], cfg[`IDX_SLP_LO]};
  wire [15:0] smd_thr = {cfg[`IDX_SMD_HI], cfg[`IDX_SMD_LO]};
  wire [15:0] hg_thr = {cfg[`IDX_HG_HI], cfg[`IDX_HG_LO]};
  wire [15:0] lg_thr = {cfg[`IDX_LG_HI], cfg[`IDX_LG_LO]};
  wire [WM_BITS-1:0] wm_level = {cfg[`IDX_WM_HI][2:0], cfg[`IDX_WM_LO]};
  wire [1:0] omode = cfg[`IDX_OCFG][1:0];
  wire [1:0] blk = cfg[`IDX_OCFG][3:2];
  wire updn_mode = cfg[`IDX_UPDN][`B_UPDN];
  wire latched = cfg[`IDX_ROUTE][`B_LATCH];
  wire to_pin2 = cfg[`IDX_ROUTE][`B_TO_PIN2];
  wire [3:0] pulse_len = cfg[`IDX_ROUTE][7:4];

  // magnitudes and slopes of the 16-bit samples
  wire [17:0] ax = abs18({{2{acc_x[15]}}, acc_x});
  wire [17:0] ay = abs18({{2{acc_y[15]}}, acc_y});
  wire [17:0] az = abs18({{2{acc_z[15]}}, acc_z});
  wire [17:0] sx = abs18({{2{acc_x[15]}}, acc_x} - {{2{px_reg[15]}}, px_reg});
  wire [17:0] sy = abs18({{2{acc_y[15]}}, acc_y} - {{2{py_reg[15]}}, py_reg});
  wire [17:0] sz = abs18({{2{acc_z[15]}}, acc_z} - {{2{pz_reg[15]}}, pz_reg});
  wire [19:0] axe = {2'b00, ax};
  wire [19:0] aye = {2'b00, ay};
  wire [19:0] he = {4'h0, hyst};

  // landscape / portrait comparisons per mode, scaled to avoid division
  reg land, port;
  always @* begin
    case (omode)
      `OMODE_HIGH: begin
        land = aye + (he << 1) < (axe << 1);
        port = aye > (axe << 1) + he;
      end
      `OMODE_LOW: begin
        land = (aye << 1) + he < axe;
        port = (aye << 1) > axe + (he << 1);
      end
      default: begin
        land = aye + he < axe;
        port = aye > axe + he;
      end
    endcase
  end

  // new code; inside the band the old one stays
  wire [1:0] ocode_next = land ? {1'b0, acc_x[15]} :
                          port ? {1'b1, ~acc_y[15]} : ocode_reg;
  wire down_next = (az > {2'b00, hyst}) ? acc_z[15] : down_reg;
  wire ochange = updn_mode ? (down_next != down_reg) : (ocode_next != ocode_reg);

  // blocking conditions
  reg [6:0] since_ms_reg;
  wire near_horiz = ({ax[16:0], 1'b0} + {ay[16:0], 1'b0}) < az;
  wire [17:0] big_e = {2'b00, big_lim};
  wire over_big = (ax > big_e) || (ay > big_e) || (az > big_e);
  wire [17:0] slp_e = {2'b00, slp_thr};
  wire [17:0] slp2_e = {1'b0, slp_thr, 1'b0};
  reg blocked;
  always @* begin
    case (blk)
      `BLK_OFF: blocked = 1'b0;
      `BLK_BASIC: blocked = near_horiz || over_big;
      `BLK_SLOPE: blocked = near_horiz || over_big || over_any(sx, sy, sz, slp_e);
      default: blocked = near_horiz || over_big || over_any(sx, sy, sz, slp2_e) ||
                         (since_ms_reg < BLOCK_MS_L);
    endcase
  end

  // one millisecond timebase
  reg [19:0] ms_cnt_reg;
  wire ms_tick = (ms_cnt_reg == MS_LAST);
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_reg <= 20'h0_0000;
    end else if (ce) begin
      ms_cnt_reg <= ms_tick ? 20'h0_0000 : ms_cnt_reg + 20'h0_0001;
    end
  end

  // orientation state, previous sample, time since last change
  always @(posedge aclk) begin
    if (!aresetn) begin
      ocode_reg <= 2'b00;
      down_reg <= 1'b0;
      px_reg <= 16'h0000;
      py_reg <= 16'h0000;
      pz_reg <= 16'h0000;
      since_ms_reg <= BLOCK_MS_L;
    end else if (ce) begin
      if (acc_valid) begin
        ocode_reg <= ocode_next;
        down_reg <= down_next;
        px_reg <= acc_x;
        py_reg <= acc_y;
        pz_reg <= acc_z;
      end
      if (acc_valid && ochange) begin
        since_ms_reg <= 7'h00;
      end else if (ms_tick && since_ms_reg < BLOCK_MS_L) begin
        since_ms_reg <= since_ms_reg + 7'h01;
      end
    end
  end

  // free-fall, low-g and high-g timers
  wire [18:0] sum3 = {1'b0, ax} + {1'b0, ay} + {1'b0, az};
  wire ff_cond = sum3 < {3'b000, cfg[`IDX_FF_THR], 8'h00};
  wire [17:0] lg_e = {2'b00, lg_thr};
  wire [17:0] hg_e = {2'b00, hg_thr};
  wire [2:0] hg_axes = cfg[`IDX_HG_AXES][2:0];
  wire lg_cond = (ax < lg_e) && (ay < lg_e) && (az < lg_e);
  wire hg_cond = (hg_axes[0] && ax > hg_e) || (hg_axes[1] && ay > hg_e) || (hg_axes[2] && az > hg_e);
  reg ff_hold_reg, ff_done_reg;
  reg [9:0] ff_ms_reg;
  reg [8:0] lg_cnt_reg, hg_cnt_reg;
  wire [9:0] ff_need = {1'b0, cfg[`IDX_FF_DUR], 1'b0};
  wire ff_fire = ff_hold_reg && !ff_done_reg && (ff_ms_reg > ff_need);
  wire lg_fire = acc_valid && lg_cond && (lg_cnt_reg == {1'b0, cfg[`IDX_LG_DUR]});
  wire hg_fire = acc_valid && hg_cond && (hg_cnt_reg == {1'b0, cfg[`IDX_HG_DUR]});
  always @(posedge aclk) begin
    if (!aresetn) begin
      ff_hold_reg <= 1'b0;
      ff_done_reg <= 1'b0;
      ff_ms_reg <= 10'h000;
      lg_cnt_reg <= 9'h000;
      hg_cnt_reg <= 9'h000;
    end else if (ce) begin
      if (acc_valid) begin
        ff_hold_reg <= ff_cond;
        lg_cnt_reg <= !lg_cond ? 9'h000 : lg_cnt_reg + {8'h00, lg_cnt_reg != 9'h1FF};
        hg_cnt_reg <= !hg_cond ? 9'h000 : hg_cnt_reg + {8'h00, hg_cnt_reg != 9'h1FF};
      end
      // count in milliseconds while the sum stays low
      if (acc_valid && !ff_cond) begin
        ff_ms_reg <= 10'h000;
        ff_done_reg <= 1'b0;
      end else begin
        if (ms_tick && ff_hold_reg && ff_ms_reg != 10'h3FF) begin
          ff_ms_reg <= ff_ms_reg + 10'h001;
        end
        if (ff_fire) begin
          ff_done_reg <= 1'b1;
        end
      end
    end
  end

  // significant motion sequencer, timed in samples
  reg [2:0] smd_state_reg;
  reg [3:0] smd_cnt_reg;
  reg smd_fire;
  wire smd_slope = over_any(sx, sy, sz, {2'b00, smd_thr});
  always @(posedge aclk) begin
    if (!aresetn) begin
      smd_state_reg <= SMD_IDLE;
      smd_cnt_reg <= 4'h0;
      smd_fire <= 1'b0;
    end else if (ce) begin
      smd_fire <= 1'b0;
      if (acc_valid) begin
        case (smd_state_reg)
          SMD_IDLE: begin
            smd_cnt_reg <= 4'h0;
            if (smd_slope) begin
              smd_state_reg <= SMD_BLOCK;
            end
          end
          SMD_BLOCK: begin
            if (smd_cnt_reg == cfg[`IDX_SMD_TIME][7:4]) begin
              smd_state_reg <= SMD_PROOF;
              smd_cnt_reg <= 4'h0;
            end else begin
              smd_cnt_reg <= smd_cnt_reg + 4'h1;
            end
          end
          SMD_PROOF: begin
            if (smd_slope) begin
              smd_fire <= 1'b1;
              smd_state_reg <= SMD_IDLE;
            end else if (smd_cnt_reg == cfg[`IDX_SMD_TIME][3:0]) begin
              smd_state_reg <= SMD_IDLE;
            end else begin
              smd_cnt_reg <= smd_cnt_reg + 4'h1;
            end
          end
          default: smd_state_reg <= SMD_IDLE;
        endcase
      end
    end
  end

  // watermark edge: fire once when the count reaches the level
  reg wm_eq_reg;
  wire wm_eq = (fifo_count == wm_level);
  always @(posedge aclk) begin
    if (!aresetn) begin
      wm_eq_reg <= 1'b0;
    end else if (ce) begin
      wm_eq_reg <= wm_eq;
    end
  end

  // event vectors gated by enables
  wire orient_fire = acc_valid && ochange && !blocked;
  wire [7:0] en1 = cfg[`IDX_EN1];
  wire [7:0] en2 = cfg[`IDX_EN2];
  wire [7:0] s1_set = {lg_fire & en1[`B_LOWG], hg_fire & en1[`B_HIGHG], 5'b00000,
                       orient_fire & en1[`B_ORIENT]};
  wire [7:0] s2_set = {3'b000, smd_fire & en2[`B_SMD], wm_eq & !wm_eq_reg & en2[`B_WM],
                       gyro_valid & en2[`B_GDRDY], acc_valid & en2[`B_ADRDY],
                       ff_fire & en2[`B_FF]};

  // axi4-lite write channel: address and data taken in either order
  reg aw_held_reg, w_held_reg;
  reg [11:0] awaddr_reg;
  reg [7:0] wbyte_reg;
  reg wlane_reg;
  assign awready = ce && !aw_held_reg;
  assign wready = ce && !w_held_reg;
  wire wr_go = ce && aw_held_reg && w_held_reg && !bvalid;
  wire wr_ok = wr_go && (awaddr_reg[11:9] == 3'b000) && wlane_reg;
  wire [6:0] wr_idx = awaddr_reg[8:2];
  wire [7:0] clr1 = (wr_ok && wr_idx == `IDX_STAT1) ? wbyte_reg : 8'h00;
  wire [7:0] clr2 = (wr_ok && wr_idx == `IDX_STAT2) ? wbyte_reg : 8'h00;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wbyte_reg <= `RST_BYTE;
      wlane_reg <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      foc_start <= 1'b0;
      foc_axis <= 2'b00;
      foc_negative <= 1'b0;
      for (i = 0; i < `REG_COUNT; i = i + 1) begin
        cfg[i] <= `RST_BYTE;
      end
    end else if (ce) begin
      foc_start <= 1'b0;
      if (awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wbyte_reg <= wdata[7:0];
        wlane_reg <= wstrb[0];
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awaddr_reg[11:9] == 3'b000) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (wr_ok) begin
        cfg[wr_idx] <= wbyte_reg;
      end
      // fast offset compensation command, gyro target zero
      if (wr_ok && wr_idx == `IDX_FOC && wbyte_reg >= `FOC_FIRST && wbyte_reg <= `FOC_LAST) begin
        foc_start <= 1'b1;
        foc_axis <= wbyte_reg[2:1];
        foc_negative <= wbyte_reg[0];
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat1_reg <= `RST_BYTE;
      stat2_reg <= `RST_BYTE;
    end else if (ce) begin
      stat1_reg <= (stat1_reg & ~clr1) | s1_set;
      stat2_reg <= (stat2_reg & ~clr2) | s2_set;
    end
  end

  // axi4-lite read channel, one cycle to answer
  wire [6:0] rd_idx = araddr[8:2];
  reg [7:0] rd_byte;
  always @* begin
    if (rd_idx == `IDX_STAT1) begin
      rd_byte = stat1_reg;
    end else if (rd_idx == `IDX_STAT2) begin
      rd_byte = stat2_reg;
    end else if (rd_idx == `IDX_ODET) begin
      rd_byte = {5'b00000, down_reg, ocode_reg};
    end else begin
      rd_byte = cfg[rd_idx];
    end
  end
  assign arready = ce && !rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (arvalid && !rvalid) begin
        rvalid <= 1'b1;
        rdata <= (araddr[11:9] == 3'b000) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        rresp <= (araddr[11:9] == 3'b000) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // pin activity: level from flags when latched, else a pulse per event
  wire motion_flags = (|stat1_reg) | stat2_reg[`B_FF] | stat2_reg[`B_SMD];
  wire data_flags = stat2_reg[`B_WM] | stat2_reg[`B_GDRDY] | stat2_reg[`B_ADRDY];
  wire motion_ev = (|s1_set) | s2_set[`B_FF] | s2_set[`B_SMD];
  wire data_ev = s2_set[`B_WM] | s2_set[`B_GDRDY] | s2_set[`B_ADRDY];
  wire [1:0] pin_lvl = {motion_flags & to_pin2, data_flags | (motion_flags & !to_pin2)};
  wire [1:0] pin_ev = {motion_ev & to_pin2, data_ev | (motion_ev & !to_pin2)};
  wire [1:0] pin_od = {cfg[`IDX_PINCFG][`B_OD2], cfg[`IDX_PINCFG][`B_OD1]};
  wire act_low = cfg[`IDX_PINCFG][`B_ACT_LOW];
  wire [1:0] pin_out;
  wire [1:0] pin_oe;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin
      reg [3:0] pulse_reg;
      reg act_reg;
      // unlatched events give a clock-like pulse of pulse_len+1 cycles
      always @(posedge aclk) begin
        if (!aresetn) begin
          pulse_reg <= 4'h0;
          act_reg <= 1'b0;
        end else if (ce) begin
          if (pin_ev[g]) begin
            pulse_reg <= pulse_len;
          end else if (pulse_reg != 4'h0) begin
            pulse_reg <= pulse_reg - 4'h1;
          end
          act_reg <= latched ? pin_lvl[g] : (pin_ev[g] || pulse_reg != 4'h0);
        end
      end
      // open drain only pulls to the inactive-high wire level's opposite
      wire lvl = act_reg ^ act_low;
      assign pin_out[g] = pin_od[g] ? 1'b0 : lvl;
      assign pin_oe[g] = pin_od[g] ? !lvl : 1'b1;
    end
  endgenerate
  assign first_interrupt_pin_out = pin_out[0];
  assign first_interrupt_pin_oe = pin_oe[0];
  assign second_interrupt_pin_out = pin_out[1];
  assign second_interrupt_pin_oe = pin_oe[1];
endmodule

// File: verif/motion_event_chk.sv
`timescale 1ns/1ns
`include "motion_regs.vh"
module motion_event_chk (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // register bus
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire [11:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  input wire rready,
  // pins and offset request
  input wire first_interrupt_pin_out,
  input wire first_interrupt_pin_oe,
  input wire second_interrupt_pin_out,
  input wire second_interrupt_pin_oe,
  input wire foc_start
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  foc_on_write_a: assert property (foc_start |-> $rose(bvalid))
    else $error("offset start without a write answer");
  foc_single_a: assert property (foc_start |=> !foc_start)
    else $error("offset start longer than one cycle");
  pin1_drain_a: assert property (!first_interrupt_pin_oe |-> !first_interrupt_pin_out)
    else $error("first pin drives high while released");
  pin2_drain_a: assert property (!second_interrupt_pin_oe |-> !second_interrupt_pin_out)
    else $error("second pin drives high while released");
  write_answer_a: assert property (awvalid && awready && wvalid && wready && !bvalid |=> ##1 bvalid)
    else $error("write answer late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read address taken while answer stands");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  unmapped_read_a: assert property (arvalid && arready && araddr[11:9] != 3'b000
    |=> rresp == `RESP_SLVERR && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

bind motion_event_engine motion_event_chk motion_event_chk_i (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .first_interrupt_pin_out(first_interrupt_pin_out), .first_interrupt_pin_oe(first_interrupt_pin_oe),
  .second_interrupt_pin_out(second_interrupt_pin_out), .second_interrupt_pin_oe(second_interrupt_pin_oe),
  .foc_start(foc_start));

// File: verif/host_model.sv
`timescale 1ns/1ns
module host_model (
  // clock
  input wire aclk,
  // write channels
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  output logic bready,
  // read channels
  output logic [11:0] araddr,
  output logic arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire [1:0] rresp,
  input wire rvalid,
  output logic rready,
  // first interrupt pin as seen on the board
  input wire first_interrupt_pin_out,
  input wire first_interrupt_pin_oe,
  output wire first_pin_level
);
  // board pull-up keeps a released open-drain pin high
  assign first_pin_level = first_interrupt_pin_oe ? first_interrupt_pin_out : 1'b1;

  // idle bus at time zero
  initial begin
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // address and data offered together, each released once taken
  task write_reg(input [11:0] a, input [7:0] d, output [1:0] resp);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h00_0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  // no assumed latency: wait as long as the slave needs
  task read_reg(input [11:0] a, output [31:0] d, output [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

// File: verif/motion_event_interrupt_engine_tb_top.sv
`timescale 1ns/1ns
`include "motion_regs.vh"
module motion_event_interrupt_engine_tb_top;
  logic aclk, aresetn, ce, acc_valid, gyro_valid;
  logic [3:0] wstrb;
  logic [15:0] acc_x, acc_y, acc_z;
  logic [10:0] fifo_count;
  wire [11:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [1:0] bresp, rresp, foc_axis;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  wire pin1_out, pin1_oe, pin1_level, foc_start, foc_negative;
  int miscompares, cmp_count, foc_count, cycles, i, n;
  logic [2:0] foc_last;
  logic [7:0] c;
  logic [31:0] d;
  logic [1:0] r;
  // mode, x, y, z, expected {downside, code}
  logic [52:0] rows [0:9];

  // short millisecond so timed events fit the run
  motion_event_engine #(.MS_CYCLES(10), .WM_BITS(11)) motion_event_engine_i (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .acc_x(acc_x), .acc_y(acc_y), .acc_z(acc_z), .acc_valid(acc_valid), .gyro_valid(gyro_valid),
    .fifo_count(fifo_count), .first_interrupt_pin_out(pin1_out), .first_interrupt_pin_oe(pin1_oe),
    .second_interrupt_pin_out(), .second_interrupt_pin_oe(), .foc_start(foc_start),
    .foc_axis(foc_axis), .foc_negative(foc_negative));

  host_model host_model_i (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .first_interrupt_pin_out(pin1_out), .first_interrupt_pin_oe(pin1_oe),
    .first_pin_level(pin1_level));

  always #10 aclk = ~aclk;

  task finish_test;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task check_val(input [31:0] got, input [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input [6:0] idx, input [7:0] v);
    host_model_i.write_reg({3'b000, idx, 2'b00}, v, r);
    check_val({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask

  // masked bits judged
  task rd_chk(input [6:0] idx, input [7:0] mask, input [7:0] exp);
    host_model_i.read_reg({3'b000, idx, 2'b00}, d, r);
    check_val({24'h00_0000, d[7:0] & mask}, {24'h00_0000, exp});
  endtask

  task sample(input [15:0] x, input [15:0] y, input [15:0] z);
    @(posedge aclk);
    acc_x <= x;
    acc_y <= y;
    acc_z <= z;
    acc_valid <= 1'b1;
    @(posedge aclk);
    acc_valid <= 1'b0;
  endtask

  // offset pulse monitor and hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (foc_start === 1'b1) begin
      foc_count <= foc_count + 1;
      foc_last <= {foc_axis, foc_negative};
    end
    if (cycles == 8000) begin
      miscompares++;
      finish_test;
    end
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    wstrb = 4'hf;
    acc_x = 16'h0000;
    acc_y = 16'h0000;
    acc_z = 16'h0000;
    acc_valid = 1'b0;
    gyro_valid = 1'b0;
    fifo_count = 11'h000;
    {miscompares, cmp_count, foc_count, cycles} = '0;
    rows = '{{2'b00, 16'h1000, 16'h0000, 16'h4000, 3'b000}, {2'b00, 16'hf000, 16'h0000, 16'hc000, 3'b101},
      {2'b00, 16'h0000, 16'hf000, 16'hc000, 3'b110}, {2'b00, 16'h0000, 16'h1000, 16'h4000, 3'b011},
      {2'b00, 16'h1000, 16'h0f80, 16'h0080, 3'b011}, {2'b01, 16'h1000, 16'h1800, 16'h4000, 3'b000},
      {2'b01, 16'h0800, 16'h1800, 16'h4000, 3'b011}, {2'b10, 16'h1000, 16'h0900, 16'h4000, 3'b011},
      {2'b10, 16'hf000, 16'h0700, 16'h4000, 3'b001}, {2'b10, 16'h1000, 16'hf6ff, 16'h4000, 3'b010}};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // cleared state after reset
    rd_chk(`IDX_STAT1, 8'hff, 8'h00);
    rd_chk(`IDX_STAT2, 8'hff, 8'h00);
    rd_chk(`IDX_ODET, 8'hff, 8'h00);
    host_model_i.read_reg(12'h800, d, r);
    check_val({30'h0, r}, {30'h0, `RESP_SLVERR});
    check_val(d, 32'h0000_0000);
    wr(`IDX_EN1, 8'hc1);
    wr(`IDX_EN2, 8'h1f);
    wr(`IDX_HYS_LO, 8'h00);
    wr(`IDX_HYS_HI, 8'h01);
    // orientation table, rows depend on the one before
    for (i = 0; i < 10; i++) begin
      wr(`IDX_OCFG, {6'h00, rows[i][52:51]});
      sample(rows[i][50:35], rows[i][34:19], rows[i][18:3]);
      rd_chk(`IDX_ODET, 8'h07, {5'h00, rows[i][2:0]});
    end
    rd_chk(`IDX_STAT1, 8'h01, 8'h01);
    wr(`IDX_STAT1, 8'h01);
    rd_chk(`IDX_STAT1, 8'h01, 8'h00);
    // large acceleration blocks the event, not the detail
    wr(`IDX_OCFG, 8'h04);
    wr(`IDX_LIM_LO, 8'h00);
    wr(`IDX_LIM_HI, 8'h20);
    sample(16'h3000, 16'h0000, 16'h4000);
    rd_chk(`IDX_ODET, 8'h07, 8'h00);
    rd_chk(`IDX_STAT1, 8'h01, 8'h00);
    sample(16'h1000, 16'h1800, 16'h1000);
    rd_chk(`IDX_STAT1, 8'h01, 8'h01);
    wr(`IDX_OCFG, 8'h08);
    wr(`IDX_SLP_HI, 8'h10);
    wr(`IDX_STAT1, 8'h01);
    sample(16'h1000, 16'h0000, 16'h1000);
    rd_chk(`IDX_STAT1, 8'h01, 8'h00);
    // up-down mode ignores turns about z
    wr(`IDX_OCFG, 8'h00);
    wr(`IDX_UPDN, 8'h80);
    wr(`IDX_STAT1, 8'h01);
    sample(16'h1000, 16'h0000, 16'h4000);
    rd_chk(`IDX_STAT1, 8'h01, 8'h00);
    sample(16'h1000, 16'h0000, 16'hc000);
    rd_chk(`IDX_STAT1, 8'h01, 8'h01);
    wr(`IDX_UPDN, 8'h00);
    // low-g then high-g, each fires on the third sample that meets its condition
    wr(`IDX_LG_HI, 8'h04);
    wr(`IDX_LG_DUR, 8'h02);
    wr(`IDX_HG_HI, 8'h20);
    wr(`IDX_HG_DUR, 8'h02);
    wr(`IDX_HG_AXES, 8'h01);
    wr(`IDX_STAT1, 8'hff);
    for (i = 1; i <= 3; i++) begin
      sample(16'h0100, 16'h0100, 16'h0100);
      rd_chk(`IDX_STAT1, 8'h80, (i == 3) ? 8'h80 : 8'h00);
    end
    for (i = 1; i <= 6; i++) begin
      sample((i > 3) ? 16'h3000 : 16'h0000, (i > 3) ? 16'h0000 : 16'h3000, 16'h0000);
      rd_chk(`IDX_STAT1, 8'h40, (i == 6) ? 8'h40 : 8'h00);
    end
    // free-fall needs over two milliseconds of low sum
    wr(`IDX_FF_THR, 8'h10);
    wr(`IDX_FF_DUR, 8'h01);
    wr(`IDX_STAT2, 8'hff);
    sample(16'h0100, 16'h0100, 16'h0100);
    rd_chk(`IDX_STAT2, 8'h01, 8'h00);
    repeat (6) begin
      sample(16'h0100, 16'h0100, 16'h0100);
      repeat (8) @(posedge aclk);
    end
    rd_chk(`IDX_STAT2, 8'h01, 8'h01);
    // two slopes separated by the block period
    wr(`IDX_SMD_HI, 8'h02);
    wr(`IDX_SMD_TIME, 8'h13);
    wr(`IDX_STAT2, 8'hff);
    for (i = 0; i < 6; i++)
      sample(i[0] ? 16'h1000 : 16'h0000, 16'h0000, 16'h0000);
    rd_chk(`IDX_STAT2, 8'h10, 8'h10);
    // watermark and data-ready
    wr(`IDX_WM_LO, 8'h05);
    wr(`IDX_STAT2, 8'hff);
    @(posedge aclk) fifo_count <= 11'h004;
    rd_chk(`IDX_STAT2, 8'h08, 8'h00);
    @(posedge aclk) fifo_count <= 11'h005;
    rd_chk(`IDX_STAT2, 8'h08, 8'h08);
    @(posedge aclk) gyro_valid <= 1'b1;
    @(posedge aclk) gyro_valid <= 1'b0;
    rd_chk(`IDX_STAT2, 8'h06, 8'h04);
    sample(16'h0000, 16'h0000, 16'h4000);
    rd_chk(`IDX_STAT2, 8'h02, 8'h02);
    // offset commands and neighbours
    for (i = 0; i < 8; i++) begin
      c = 8'h8f + i[7:0];
      n = foc_count;
      wr(`IDX_FOC, c);
      repeat (2) @(posedge aclk);
      check_val(foc_count - n, (c >= `FOC_FIRST && c <= `FOC_LAST) ? 1 : 0);
      if (c >= `FOC_FIRST && c <= `FOC_LAST) check_val({29'h0, foc_last}, {29'h0, c[2:0]});
    end
    // idle pin level for each drive style
    wr(`IDX_PINCFG, 8'h80);
    repeat (3) @(posedge aclk);
    check_val({31'h0, pin1_level}, 32'h0000_0001);
    wr(`IDX_PINCFG, 8'h82);
    repeat (3) @(posedge aclk);
    check_val({31'h0, pin1_oe}, 32'h0000_0000);
    wr(`IDX_PINCFG, 8'h00);
    repeat (3) @(posedge aclk);
    check_val({31'h0, pin1_level}, 32'h0000_0000);
    finish_test;
  end
endmodule
